// ===== rtc_pkg.sv
// Constants and types shared by the clock-calendar memory port.
package rtc_pkg;

    // ------------------------------------------------------------
    // Memory geometry and clock register area
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 131072;
    localparam logic [13:0] CLK_AREA_TAG = 14'h3FFF;

    // Register indices within the eight clock locations.
    localparam logic [2:0] IDX_CTL = 3'h0;
    localparam logic [2:0] IDX_SEC = 3'h1;
    localparam logic [2:0] IDX_MIN = 3'h2;
    localparam logic [2:0] IDX_HOUR = 3'h3;
    localparam logic [2:0] IDX_DAY = 3'h4;
    localparam logic [2:0] IDX_DATE = 3'h5;
    localparam logic [2:0] IDX_MONTH = 3'h6;
    localparam logic [2:0] IDX_YEAR = 3'h7;

    // Control and seconds byte bit positions.
    localparam int CTL_WHALT_BIT = 7;
    localparam int CTL_RHALT_BIT = 6;
    localparam int SEC_OSC_STOP_BIT = 7;

    // Writable bits of each clock register, unused bits store zero.
    localparam logic [7:0] MASK_CTL = 8'h3F;
    localparam logic [7:0] MASK_SEC = 8'hFF;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_DAY = 8'h47;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;

    // Values after reset: century 20, 1 January of year 00, day 1.
    localparam logic [7:0] RST_CENTURY = 8'h20;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // One second expressed in clock cycles at 40 MHz.
    localparam int CLK_PERIOD_NS = 25;
    localparam int SECOND_NS = 1000000000;
    localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 26;

    // Eight clock bytes, index as above.
    typedef logic [7:0][7:0] rtc_time_t;

    // Whole register state of the port; the memory array is kept apart.
    typedef struct packed {
        logic [1:0] ce_n_sync;
        logic [1:0] oe_n_sync;
        logic [1:0] we_n_sync;
        logic [1:0] pf_sync;
        logic [ADDR_W-1:0] addr_s1;
        logic [ADDR_W-1:0] addr_s2;
        logic [DATA_W-1:0] din_s1;
        logic [DATA_W-1:0] din_s2;
        logic wr_active;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic [DATA_W-1:0] dout;
        logic doe;
        logic pf_oe;
        logic pf_level;
        logic [TICK_W-1:0] tick_cnt;
        logic ctl_w;
        logic ctl_r;
        rtc_time_t cnt;
        rtc_time_t vis;
    } rtc_state_t;

endpackage

// ===== rtc_port.sv
// Byte-wide clock-calendar with static memory behind an asynchronous memory bus.
`timescale 1ns/10ps
`default_nettype none
// Function
// - 128k by 8 memory, 17 address, 8 data
// - Clock registers occupy eight highest addresses
// - BCD century-to-seconds, 24-hour hours
// - Month lengths and leap day applied automatically
// - Counter runs while visible copy is read
// - Read-halt bit 6 freezes visible registers
// - Frozen registers hold time at halt
// - Internal counter keeps advancing during halt
// - Visible registers reload all at once
// - Refresh within one second after halt cleared
// - Chip deselected: ignore strobes, data released
// - Select and write strobe low mean write
// - Select, output enable low, write strobe high: drive data
// - Both strobes high: released, no write
// - Power fail deselects and blocks all access
// - Open-drain active-low power-fail output
// - Control at lowest clock address, W R century
module rtc_port #(
    parameter int TICK_CYCLES = rtc_pkg::SECOND_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic [rtc_pkg::ADDR_W-1:0] addr_line,
    input wire logic [rtc_pkg::DATA_W-1:0] data_line_in,
    output logic [rtc_pkg::DATA_W-1:0] data_line_out,
    output logic data_line_oe,
    input wire logic below_power_fail_threshold,
    output logic power_fail_n_out,
    output logic power_fail_n_oe
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // True when an address falls in the clock register area.
    function automatic logic is_clock(input logic [rtc_pkg::ADDR_W-1:0] a);
        return a[rtc_pkg::ADDR_W-1:3] == rtc_pkg::CLK_AREA_TAG;
    endfunction

    // Writable bits of a clock register.
    function automatic logic [7:0] reg_mask(input logic [2:0] idx);
        logic [7:0] m;
        m = rtc_pkg::MASK_YEAR;
        unique case (idx)
            rtc_pkg::IDX_CTL: m = rtc_pkg::MASK_CTL;
            rtc_pkg::IDX_SEC: m = rtc_pkg::MASK_SEC;
            rtc_pkg::IDX_MIN: m = rtc_pkg::MASK_MIN;
            rtc_pkg::IDX_HOUR: m = rtc_pkg::MASK_HOUR;
            rtc_pkg::IDX_DAY: m = rtc_pkg::MASK_DAY;
            rtc_pkg::IDX_DATE: m = rtc_pkg::MASK_DATE;
            rtc_pkg::IDX_MONTH: m = rtc_pkg::MASK_MONTH;
            rtc_pkg::IDX_YEAR: m = rtc_pkg::MASK_YEAR;
        endcase
        return m;
    endfunction

    // BCD increment with wrap from hi to lo; bit 8 is the carry out.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        logic [8:0] r;
        r = {1'b0, v + 8'h01};
        if (v >= hi)
        begin
            r = {1'b1, lo};
        end
        else if (v[3:0] == 4'h9)
        begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    // Last date of a month, with leap years every fourth year.
    function automatic logic [7:0] month_end(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        logic [7:0] d;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        d = 8'h31;
        if (month == 8'h02)
        begin
            d = leap ? 8'h29 : 8'h28;
        end
        else if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h11)
        begin
            d = 8'h30;
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    rtc_pkg::rtc_state_t st_reg;
    rtc_pkg::rtc_state_t st_next;
    logic [rtc_pkg::DATA_W-1:0] mem [rtc_pkg::MEM_DEPTH];
    logic mem_wr;
    logic tick;
    logic [8:0] inc;
    logic carry;
    logic [2:0] widx;
    logic [7:0] wbyte;
    logic [7:0] mem_rd;

    // Plain memory read at the synchronised address.
    assign mem_rd = mem[st_reg.addr_s2];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Synchronises the pins, runs the calendar and decodes bus cycles.
    always_comb
    begin
        st_next = st_reg;
        mem_wr = 1'b0;
        tick = 1'b0;
        inc = 9'h000;
        carry = 1'b0;
        widx = st_reg.wr_addr[2:0];
        wbyte = st_reg.wr_data & reg_mask(st_reg.wr_addr[2:0]);

        // Two-flop synchronisers on every pin.
        st_next.ce_n_sync = {st_reg.ce_n_sync[0], chip_sel_n};
        st_next.oe_n_sync = {st_reg.oe_n_sync[0], out_en_n};
        st_next.we_n_sync = {st_reg.we_n_sync[0], wr_en_n};
        st_next.pf_sync = {st_reg.pf_sync[0], below_power_fail_threshold};
        st_next.addr_s1 = addr_line;
        st_next.addr_s2 = st_reg.addr_s1;
        st_next.din_s1 = data_line_in;
        st_next.din_s2 = st_reg.din_s1;

        // One-second divider, stopped by the oscillator stop bit.
        if (st_reg.cnt[rtc_pkg::IDX_SEC][rtc_pkg::SEC_OSC_STOP_BIT])
        begin
            st_next.tick_cnt = '0;
        end
        else if (st_reg.tick_cnt == rtc_pkg::TICK_W'(TICK_CYCLES - 1))
        begin
            st_next.tick_cnt = '0;
            tick = 1'b1;
        end
        else
        begin
            st_next.tick_cnt = st_reg.tick_cnt + rtc_pkg::TICK_W'(1);
        end

        // Counter advances every tick, halts or not.
        if (tick)
        begin
            inc = bcd_inc({1'b0, st_reg.cnt[rtc_pkg::IDX_SEC][6:0]}, 8'h00, 8'h59);
            st_next.cnt[rtc_pkg::IDX_SEC][6:0] = inc[6:0];
            carry = inc[8];
            if (carry)
            begin
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_MIN], 8'h00, 8'h59);
                st_next.cnt[rtc_pkg::IDX_MIN] = inc[7:0];
                carry = inc[8];
            end
            if (carry)
            begin
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_HOUR], 8'h00, 8'h23);
                st_next.cnt[rtc_pkg::IDX_HOUR] = inc[7:0];
                carry = inc[8];
            end
            if (carry)
            begin
                inc = bcd_inc({5'h00, st_reg.cnt[rtc_pkg::IDX_DAY][2:0]}, 8'h01, 8'h07);
                st_next.cnt[rtc_pkg::IDX_DAY][2:0] = inc[2:0];
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_DATE], 8'h01,
                              month_end(st_reg.cnt[rtc_pkg::IDX_MONTH], st_reg.cnt[rtc_pkg::IDX_YEAR]));
                st_next.cnt[rtc_pkg::IDX_DATE] = inc[7:0];
                carry = inc[8];
            end
            if (carry)
            begin
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_MONTH], 8'h01, 8'h12);
                st_next.cnt[rtc_pkg::IDX_MONTH] = inc[7:0];
                carry = inc[8];
            end
            if (carry)
            begin
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_YEAR], 8'h00, 8'h99);
                st_next.cnt[rtc_pkg::IDX_YEAR] = inc[7:0];
                carry = inc[8];
            end
            if (carry)
            begin
                inc = bcd_inc(st_reg.cnt[rtc_pkg::IDX_CTL], 8'h00, 8'h39);
                st_next.cnt[rtc_pkg::IDX_CTL] = inc[7:0];
            end
        end

        // A write cycle is select and write strobe low while power is good.
        st_next.wr_active = !st_reg.ce_n_sync[1] && !st_reg.we_n_sync[1] && !st_reg.pf_sync[1];
        if (st_next.wr_active)
        begin
            st_next.wr_addr = st_reg.addr_s2;
            st_next.wr_data = st_reg.din_s2;
        end

        // The write takes effect at its end, unless power failed meanwhile.
        if (st_reg.wr_active && !st_next.wr_active && !st_reg.pf_sync[1])
        begin
            if (!is_clock(st_reg.wr_addr))
            begin
                mem_wr = 1'b1;
            end
            else if (widx == rtc_pkg::IDX_CTL)
            begin
                if (st_reg.wr_data[rtc_pkg::CTL_WHALT_BIT] || st_reg.wr_data[rtc_pkg::CTL_RHALT_BIT])
                begin
                    // Setting a halt bit leaves the century alone.
                    st_next.ctl_w = st_reg.wr_data[rtc_pkg::CTL_WHALT_BIT];
                    st_next.ctl_r = st_reg.wr_data[rtc_pkg::CTL_RHALT_BIT];
                end
                else if (st_reg.ctl_w)
                begin
                    // Leaving write halt loads the new setting into the counter.
                    st_next.ctl_w = 1'b0;
                    st_next.ctl_r = 1'b0;
                    st_next.cnt = st_reg.vis;
                    st_next.cnt[rtc_pkg::IDX_CTL] = wbyte;
                    st_next.tick_cnt = '0;
                end
                else
                begin
                    st_next.ctl_r = 1'b0;
                end
            end
            else
            begin
                st_next.vis[widx] = wbyte;
            end
        end

        // Visible copy follows the counter in one transfer unless halted.
        if (!st_next.ctl_r && !st_next.ctl_w)
        begin
            st_next.vis = st_next.cnt;
        end

        // Read data from the visible clock copy or the memory.
        if (is_clock(st_reg.addr_s2))
        begin
            st_next.dout = st_reg.vis[st_reg.addr_s2[2:0]];
            if (st_reg.addr_s2[2:0] == rtc_pkg::IDX_CTL)
            begin
                st_next.dout = {st_reg.ctl_w, st_reg.ctl_r, st_reg.vis[rtc_pkg::IDX_CTL][5:0]};
            end
        end
        else
        begin
            st_next.dout = mem_rd;
        end

        // Data lines driven only in a read cycle with power good.
        st_next.doe = !st_reg.ce_n_sync[1] && !st_reg.oe_n_sync[1] && st_reg.we_n_sync[1]
                      && !st_reg.pf_sync[1];

        // Open-drain power-fail output pulls low while supply is low.
        st_next.pf_oe = st_reg.pf_sync[1];
        st_next.pf_level = 1'b0;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // State register with asynchronous reset.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
            st_reg.ce_n_sync <= 2'h3;
            st_reg.oe_n_sync <= 2'h3;
            st_reg.we_n_sync <= 2'h3;
            st_reg.cnt[rtc_pkg::IDX_CTL] <= rtc_pkg::RST_CENTURY;
            st_reg.cnt[rtc_pkg::IDX_SEC] <= rtc_pkg::RST_ZERO;
            st_reg.cnt[rtc_pkg::IDX_MIN] <= rtc_pkg::RST_ZERO;
            st_reg.cnt[rtc_pkg::IDX_HOUR] <= rtc_pkg::RST_ZERO;
            st_reg.cnt[rtc_pkg::IDX_DAY] <= rtc_pkg::RST_DAY;
            st_reg.cnt[rtc_pkg::IDX_DATE] <= rtc_pkg::RST_DATE;
            st_reg.cnt[rtc_pkg::IDX_MONTH] <= rtc_pkg::RST_MONTH;
            st_reg.cnt[rtc_pkg::IDX_YEAR] <= rtc_pkg::RST_YEAR;
            st_reg.vis[rtc_pkg::IDX_CTL] <= rtc_pkg::RST_CENTURY;
            st_reg.vis[rtc_pkg::IDX_DAY] <= rtc_pkg::RST_DAY;
            st_reg.vis[rtc_pkg::IDX_DATE] <= rtc_pkg::RST_DATE;
            st_reg.vis[rtc_pkg::IDX_MONTH] <= rtc_pkg::RST_MONTH;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Memory array write port, lower addresses only.
    always_ff @(posedge clk)
    begin
        if (mem_wr)
        begin
            mem[st_reg.wr_addr] <= st_reg.wr_data;
        end
    end

    // Outputs straight from flip-flops.
    assign data_line_out = st_reg.dout;
    assign data_line_oe = st_reg.doe;
    assign power_fail_n_out = st_reg.pf_level;
    assign power_fail_n_oe = st_reg.pf_oe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Read-halt bit set in this cycle and the one before.
    sequence read_halt_held;
        st_reg.ctl_r && $past(st_reg.ctl_r);
    endsequence

    // Both halts clear for two cycles in a row.
    sequence updating_on;
        !st_reg.ctl_r && !st_reg.ctl_w ##1 !st_reg.ctl_r && !st_reg.ctl_w;
    endsequence

    deselect_release_a: assert property (st_reg.ce_n_sync[1] |=> !data_line_oe)
        else $error("Data lines driven while deselected.");
    write_no_drive_a: assert property (!st_reg.ce_n_sync[1] && !st_reg.we_n_sync[1] |=> !data_line_oe)
        else $error("Data lines driven during write cycle.");
    read_drive_a: assert property (!st_reg.ce_n_sync[1] && !st_reg.oe_n_sync[1] && st_reg.we_n_sync[1]
        && !st_reg.pf_sync[1] |=> data_line_oe)
        else $error("Read cycle did not drive the data lines.");
    idle_release_a: assert property (!st_reg.ce_n_sync[1] && st_reg.oe_n_sync[1] && st_reg.we_n_sync[1]
        |=> !data_line_oe && !st_reg.wr_active)
        else $error("Idle selected cycle drove data or wrote.");
    power_block_a: assert property (st_reg.pf_sync[1] |=> !data_line_oe && !mem_wr)
        else $error("Access allowed during power failure.");
    power_flag_a: assert property (st_reg.pf_sync[1] |=> power_fail_n_oe && !power_fail_n_out)
        else $error("Power-fail output not pulled low.");
    halt_freeze_a: assert property (read_halt_held ##0 !$past(st_reg.wr_active) |-> $stable(st_reg.vis))
        else $error("Visible time changed during read halt.");
    count_runs_a: assert property (tick && st_reg.ctl_r |=> st_reg.cnt != $past(st_reg.cnt))
        else $error("Counter stopped during read halt.");
    refresh_all_a: assert property (updating_on |-> st_reg.vis == st_reg.cnt)
        else $error("Visible copy not refreshed from counter.");
    low_mem_a: assert property (mem_wr |=> st_reg.ctl_r == $past(st_reg.ctl_r)
        && st_reg.ctl_w == $past(st_reg.ctl_w))
        else $error("Memory write disturbed clock control.");

endmodule // rtc_port
`default_nettype wire

// ===== rtc_host.sv
// Host processor model driving the byte-wide clock-calendar memory bus.
`timescale 1ns/10ps
`default_nettype none
module rtc_host (
    input wire logic clk,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_en_n,
    output logic [rtc_pkg::ADDR_W-1:0] addr_line,
    output logic [rtc_pkg::DATA_W-1:0] data_line_in,
    input wire logic [rtc_pkg::DATA_W-1:0] data_line_out,
    input wire logic data_line_oe
);
    logic host_drive;
    logic [7:0] host_data;
    logic [7:0] float_reg;

    // ------------------------------------------------------------
    // Data wire
    // ------------------------------------------------------------
    // The wire carries the host, else the device, else a pattern that flips every cycle.
    assign data_line_in = host_drive ? host_data : (data_line_oe ? data_line_out : float_reg);

    // A released bus never keeps its last value, so stale data cannot pass for a read.
    always @(posedge clk)
    begin
        float_reg <= ~data_line_in;
    end

    // Bus idles deselected with strobes high.
    initial
    begin
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        wr_en_n = 1'b1;
        addr_line = '0;
        host_drive = 1'b0;
        host_data = 8'h00;
        float_reg = 8'h5A;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Write: strobes low four cycles, then raised together; address and data held four more.
    task automatic bus_write(input logic [16:0] a, input logic [7:0] d, input logic cs_n, input logic oe_n,
                             output logic drove);
        drove = 1'b0;
        @(negedge clk);
        addr_line = a;
        host_data = d;
        host_drive = 1'b1;
        chip_sel_n = cs_n;
        out_en_n = oe_n;
        wr_en_n = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            drove = drove | data_line_oe;
        end
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        wr_en_n = 1'b1;
        repeat (4) @(negedge clk);
        host_drive = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    // Read: pins held four cycles, data and drive sampled before release.
    task automatic bus_read(input logic [16:0] a, input logic cs_n, input logic oe_n,
                            output logic [7:0] d, output logic oe);
        @(negedge clk);
        addr_line = a;
        chip_sel_n = cs_n;
        out_en_n = oe_n;
        wr_en_n = 1'b1;
        repeat (4) @(negedge clk);
        d = data_line_out;
        oe = data_line_oe;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
endmodule // rtc_host
`default_nettype wire

// ===== rtc_port_test.sv
// Self-checking testbench for the clock-calendar memory port.
`timescale 1ns/10ps
`default_nettype none
module rtc_port_test;
    localparam int TICKS = 40;
    typedef struct packed {
        logic [7:0] yr, mo, dt, dy, e_yr, e_mo, e_dt, e_dy, e_ctl;
    } rtc_row_t;
    rtc_row_t rows [5] = '{
        '{8'h04, 8'h02, 8'h28, 8'h03, 8'h04, 8'h02, 8'h29, 8'h04, 8'h61},
        '{8'h03, 8'h02, 8'h28, 8'h07, 8'h03, 8'h03, 8'h01, 8'h01, 8'h61},
        '{8'h04, 8'h04, 8'h30, 8'h02, 8'h04, 8'h05, 8'h01, 8'h03, 8'h61},
        '{8'h05, 8'h01, 8'h31, 8'h05, 8'h05, 8'h02, 8'h01, 8'h06, 8'h61},
        '{8'h99, 8'h12, 8'h31, 8'h06, 8'h00, 8'h01, 8'h01, 8'h07, 8'h62}};
    logic clk;
    logic rst;
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic [16:0] addr_line;
    logic [7:0] data_line_in;
    logic [7:0] data_line_out;
    logic data_line_oe;
    logic below;
    logic pf_out;
    logic pf_oe;
    logic power_fail_n;
    logic [7:0] seen;
    logic oe;
    logic drove;
    logic [7:0] tv [8];
    int err_total = 0;
    int num_checks = 0;

    // Open-drain fail line with its pull-up.
    assign power_fail_n = pf_oe ? pf_out : 1'b1;

    rtc_port #(.TICK_CYCLES(TICKS)) uut (.clk(clk), .rst(rst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .wr_en_n(wr_en_n), .addr_line(addr_line), .data_line_in(data_line_in), .data_line_out(data_line_out),
        .data_line_oe(data_line_oe), .below_power_fail_threshold(below), .power_fail_n_out(pf_out),
        .power_fail_n_oe(pf_oe));
    rtc_host host (.clk(clk), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
        .addr_line(addr_line), .data_line_in(data_line_in), .data_line_out(data_line_out),
        .data_line_oe(data_line_oe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clock runs at 40 MHz.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Compares one value and counts the result.
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [16:0] ca(input logic [2:0] i);
        return {rtc_pkg::CLK_AREA_TAG, i};
    endfunction

    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        host.bus_write(a, d, 1'b0, 1'b1, drove);
    endtask

    // Selected read that must be driven with the expected byte.
    task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
        host.bus_read(a, 1'b0, 1'b0, seen, oe);
        check("read data", seen, exp);
        check("read drive", {7'h00, oe}, 8'h01);
    endtask

    // Cuts a hung run short.
    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        below = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        // Each row sets 23:59:59 on a date, lets one second pass, halts and reads all eight bytes.
        foreach (rows[i])
        begin
            tv = '{8'h80, 8'h59, 8'h59, 8'h23, rows[i].dy, rows[i].dt, rows[i].mo, rows[i].yr};
            for (int k = 0; k < 8; k++)
                wr(ca(k[2:0]), tv[k]);
            wr(ca(rtc_pkg::IDX_CTL), 8'h21);
            repeat (TICKS + 5) @(negedge clk);
            wr(ca(rtc_pkg::IDX_CTL), 8'h40);
            tv = '{rows[i].e_ctl, 8'h00, 8'h00, 8'h00, rows[i].e_dy, rows[i].e_dt, rows[i].e_mo, rows[i].e_yr};
            for (int k = 0; k < 8; k++)
                rd_chk(ca(k[2:0]), tv[k]);
            $display("test rollover row %0d done", i);
        end
        // Halted copy stays frozen while the counter runs on.
        repeat (100) @(negedge clk);
        rd_chk(ca(rtc_pkg::IDX_SEC), 8'h00);
        wr(ca(rtc_pkg::IDX_CTL), 8'h00);
        rd_chk(ca(rtc_pkg::IDX_CTL), 8'h22);
        repeat (20000) @(negedge clk);
        wr(ca(rtc_pkg::IDX_CTL), 8'h40);
        rd_chk(ca(rtc_pkg::IDX_MIN), 8'h08);
        $display("test halt done");
        // Plain memory, including a write with output enable low.
        host.bus_write(17'h00000, 8'hA5, 1'b0, 1'b0, drove);
        check("drive in write", {7'h00, drove}, 8'h00);
        wr(17'h1FFF7, 8'h3C);
        wr(17'h15555, 8'hC3);
        rd_chk(17'h00000, 8'hA5);
        rd_chk(17'h1FFF7, 8'h3C);
        rd_chk(17'h15555, 8'hC3);
        rd_chk(ca(rtc_pkg::IDX_MIN), 8'h08);
        $display("test memory done");
        // Deselected and idle cycles neither drive nor write.
        host.bus_write(17'h00000, 8'h11, 1'b1, 1'b0, drove);
        host.bus_read(17'h00000, 1'b1, 1'b0, seen, oe);
        check("deselect drive", {7'h00, oe}, 8'h00);
        host.bus_read(17'h00000, 1'b0, 1'b1, seen, oe);
        check("idle drive", {7'h00, oe}, 8'h00);
        rd_chk(17'h00000, 8'hA5);
        $display("test deselect done");
        // Supply failure blocks access and pulls the fail line low.
        @(negedge clk);
        below = 1'b1;
        repeat (4) @(negedge clk);
        check("fail line low", {7'h00, power_fail_n}, 8'h00);
        host.bus_read(17'h00000, 1'b0, 1'b0, seen, oe);
        check("drive in fail", {7'h00, oe}, 8'h00);
        wr(17'h00000, 8'h77);
        below = 1'b0;
        repeat (4) @(negedge clk);
        check("fail line high", {7'h00, power_fail_n}, 8'h01);
        rd_chk(17'h00000, 8'hA5);
        $display("test power fail done");
        // Reset in mid-run returns the clock to its start values.
        rst = 1'b1;
        repeat (2) @(negedge clk);
        check("reset drive", {6'h00, data_line_oe, pf_oe}, 8'h00);
        rst = 1'b0;
        wr(ca(rtc_pkg::IDX_CTL), 8'h40);
        tv = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
        for (int k = 0; k < 8; k++)
            rd_chk(ca(k[2:0]), tv[k]);
        $display("test reset done");
        give_verdict();
    end
endmodule // rtc_port_test
`default_nettype wire
